// *** hw/subtract_instruction_unit.sv ***
// Execution unit for the two subtract instructions of the 8-bit core.
// Assumes decode supplies one instruction per cycle with fileData already read
// for the addressed register; file writes are performed by the register file.
`include "siu_regs.svh"
module subtract_instruction_unit
  import siu_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Instruction from decode
  input  wire logic        instrValid,
  input  wire logic [13:0] instrWord,
  input  wire siu_byte_t   fileData,
  // Accumulator state
  output siu_byte_t        accum,
  // File register write
  output logic             fileWe,
  output logic [6:0]       fileAddr,
  output siu_byte_t        fileWdata,
  // Status flags
  output logic             carryFlag,
  output logic             digitCarryFlag,
  output logic             zeroFlag
);
  siu_op_e   opKind;
  siu_byte_t minuend;
  siu_byte_t diff;
  logic      cOut;
  logic      dcOut;
  logic      zOut;
  logic      toFile;
  siu_byte_t accum_reg;
  logic      fileWe_reg;
  logic [6:0] fileAddr_reg;
  siu_byte_t fileWdata_reg;
  logic      carry_reg;
  logic      dc_reg;
  logic      zero_reg;

  function automatic siu_op_e decode_op(input logic [13:0] w);
    siu_op_e k;
    k = SIU_IDLE;
    if (w[`SIU_LIT_OPC_HI:`SIU_LIT_OPC_LO] == `SIU_LIT_OPC_VAL) begin
      k = SIU_LIT;
    end else if (w[`SIU_FILE_OPC_HI:`SIU_FILE_OPC_LO] == `SIU_FILE_OPC_VAL) begin
      k = SIU_FILE;
    end
    return k;
  endfunction

  // Reference arithmetic for the checks below; kept apart from the subtractor
  // so that a datapath fault cannot be mirrored by its own check
  function automatic logic no_borrow(input siu_byte_t m, input siu_byte_t s);
    return m >= s;
  endfunction

  function automatic siu_byte_t wrap_diff(input siu_byte_t m, input siu_byte_t s);
    logic [8:0] w;
    w = {1'b1, m} - {1'b0, s};
    return w[7:0];
  endfunction

  // Words that are neither subtract encoding decode as idle and change nothing
  assign opKind = instrValid ? decode_op(instrWord) : SIU_IDLE;
  assign toFile = (opKind == SIU_FILE) && instrWord[`SIU_DEST_BIT]; // RULE3

  always_comb begin
    case (opKind)
      SIU_LIT:  minuend = instrWord[`SIU_LIT_HI:0];                  // RULE1
      SIU_FILE: minuend = fileData;                                  // RULE2
      default:  minuend = 8'h00;
    endcase
  end

  siu_sub8 u_sub (
    .minuend    (minuend),
    .subtrahend (accum_reg),
    .diff       (diff),
    .carryOut   (cOut),
    .digitCarry (dcOut),
    .zeroOut    (zOut)
  );

  // Accumulator takes the difference unless the file is the target
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      accum_reg <= `SIU_ACC_RST;
    end else if (opKind != SIU_IDLE && !toFile) begin
      accum_reg <= diff;                                             // RULE1
    end
  end

  // Address and data hold between file subtracts; only the strobe pulses
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fileWe_reg    <= 1'b0;
      fileAddr_reg  <= `SIU_ADDR_RST;
      fileWdata_reg <= `SIU_WDATA_RST;
    end else begin
      fileWe_reg <= toFile;                                          // RULE3
      if (opKind == SIU_FILE) begin
        fileAddr_reg  <= instrWord[`SIU_ADDR_HI:0];                  // RULE2
        fileWdata_reg <= diff;
      end
    end
  end

  // Flags update after either subtraction, whichever target was chosen
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      carry_reg <= `SIU_FLAG_RST;
      dc_reg    <= `SIU_FLAG_RST;
      zero_reg  <= `SIU_FLAG_RST;
    end else if (opKind != SIU_IDLE) begin
      carry_reg <= cOut;                                             // RULE4
      dc_reg    <= dcOut;                                            // RULE7
      zero_reg  <= zOut;                                             // RULE7
    end
  end

  // Every output comes straight from a flip-flop
  assign accum          = accum_reg;
  assign fileWe         = fileWe_reg;
  assign fileAddr       = fileAddr_reg;
  assign fileWdata      = fileWdata_reg;
  assign carryFlag      = carry_reg;
  assign digitCarryFlag = dc_reg;
  assign zeroFlag       = zero_reg;

  // Checks of the result paths and the flags, one edge after the instruction
  chk_lit_result: assert property (@(posedge mclk) disable iff (sys_rst) // RULE1
    (opKind == SIU_LIT) |=> (accum == $past(instrWord[7:0]) - $past(accum_reg)))
    else $error("literal subtract result wrong");

  chk_file_result: assert property (@(posedge mclk) disable iff (sys_rst) // RULE2
    (opKind == SIU_FILE) |=> (fileWdata == $past(fileData) - $past(accum_reg)))
    else $error("file subtract result wrong");

  chk_dest_select: assert property (@(posedge mclk) disable iff (sys_rst) // RULE3
    (opKind == SIU_FILE && instrWord[7]) |=> (fileWe && $stable(accum)))
    else $error("destination select wrong");

  chk_carry_pos: assert property (@(posedge mclk) disable iff (sys_rst) // RULE4
    (opKind != SIU_IDLE && minuend > accum_reg) |=> carryFlag)
    else $error("carry not set on positive result");

  chk_carry_equal: assert property (@(posedge mclk) disable iff (sys_rst) // RULE5
    (opKind != SIU_IDLE && minuend == accum_reg) |=> (carryFlag && zeroFlag))
    else $error("carry or zero wrong on equal operands");

  chk_carry_borrow: assert property (@(posedge mclk) disable iff (sys_rst) // RULE6
    (opKind != SIU_IDLE && minuend < accum_reg) |=> (!carryFlag && !zeroFlag))
    else $error("carry not cleared on borrow");

  chk_digit_carry: assert property (@(posedge mclk) disable iff (sys_rst) // RULE7
    (opKind != SIU_IDLE) |=>
      (digitCarryFlag == ($past(minuend[3:0]) >= $past(accum_reg[3:0]))))
    else $error("digit carry wrong");

  chk_flags_hold: assert property (@(posedge mclk) disable iff (sys_rst) // RULE7
    (opKind == SIU_IDLE) |=> ($stable(zeroFlag) && $stable(carryFlag) && !fileWe))
    else $error("flags changed without a subtract");

  // Address and data outputs must follow every file subtract, whatever the target
  chk_file_addr: assert property (@(posedge mclk) disable iff (sys_rst) // RULE2
    (opKind == SIU_FILE) |=> (fileAddr == $past(instrWord[`SIU_ADDR_HI:0])))
    else $error("file address wrong");

  chk_file_hold: assert property (@(posedge mclk) disable iff (sys_rst) // RULE2
    (opKind != SIU_FILE) |=> ($stable(fileAddr) && $stable(fileWdata)))
    else $error("file outputs changed without a file subtract");

  chk_file_to_acc: assert property (@(posedge mclk) disable iff (sys_rst) // RULE3
    (opKind == SIU_FILE && !instrWord[`SIU_DEST_BIT]) |=>
      (!fileWe && accum == wrap_diff($past(fileData), $past(accum_reg))))
    else $error("accumulator target wrong");

  chk_we_source: assert property (@(posedge mclk) disable iff (sys_rst) // RULE3
    fileWe |-> $past(toFile))
    else $error("file write without a file target");

  chk_lit_no_write: assert property (@(posedge mclk) disable iff (sys_rst) // RULE1
    (opKind == SIU_LIT) |=> !fileWe)
    else $error("literal subtract wrote the file");

  // Refused words must leave the accumulator alone and raise no file write, even with instrValid high
  chk_refused_word: assert property (@(posedge mclk) disable iff (sys_rst) // RULE2
    (instrValid && opKind == SIU_IDLE) |=> (!fileWe && $stable(accum)))
    else $error("refused word changed state");

  chk_idle_accum: assert property (@(posedge mclk) disable iff (sys_rst) // RULE1
    (opKind == SIU_IDLE) |=> $stable(accum))
    else $error("accumulator changed without a subtract");

  chk_idle_dc: assert property (@(posedge mclk) disable iff (sys_rst) // RULE7
    (opKind == SIU_IDLE) |=> $stable(digitCarryFlag))
    else $error("digit carry changed without a subtract");

  // Exact flag values, so a stuck flag cannot hide behind the one-sided checks
  chk_carry_value: assert property (@(posedge mclk) disable iff (sys_rst) // RULE4
    (opKind != SIU_IDLE) |=>
      (carryFlag == no_borrow($past(minuend), $past(accum_reg))))
    else $error("carry value wrong");

  chk_zero_value: assert property (@(posedge mclk) disable iff (sys_rst) // RULE7
    (opKind != SIU_IDLE) |=> (zeroFlag == ($past(minuend) == $past(accum_reg))))
    else $error("zero flag value wrong");

  chk_equal_result: assert property (@(posedge mclk) disable iff (sys_rst) // RULE5
    (opKind != SIU_IDLE && !toFile && minuend == accum_reg) |=> (accum == 8'h00))
    else $error("equal operands did not give zero");

  // Borrow results wrap modulo 256 in both targets
  chk_borrow_wrap: assert property (@(posedge mclk) disable iff (sys_rst) // RULE6
    (opKind != SIU_IDLE && !toFile && minuend < accum_reg) |=>
      (accum == wrap_diff($past(minuend), $past(accum_reg))))
    else $error("wrapped accumulator result wrong");

  chk_borrow_file: assert property (@(posedge mclk) disable iff (sys_rst) // RULE6
    (toFile && minuend < accum_reg) |=>
      (fileWe && fileWdata == wrap_diff($past(minuend), $past(accum_reg))))
    else $error("wrapped file result wrong");
endmodule

// *** common/siu_regs.svh ***
// Constants of the subtract instruction unit: opcode fields and reset values.
// Assumes a 14-bit instruction word delivered by the core's decode stage.
// Functional notes
// (RULE1) Literal minus accumulator written to accumulator.
// (RULE2) File register minus accumulator, 7-bit address.
// (RULE3) Destination bit picks accumulator or file register.
// (RULE4) Carry set when result positive, no borrow.
// (RULE5) Carry set when operands equal, zero result.
// (RULE6) Carry cleared on borrow; result wraps.
// (RULE7) Zero on zero result; digit carry without nibble borrow.
`ifndef SIU_REGS_SVH
`define SIU_REGS_SVH
`define SIU_LIT_OPC_HI   13
`define SIU_LIT_OPC_LO   9
`define SIU_LIT_OPC_VAL  5'h1e
`define SIU_FILE_OPC_HI  13
`define SIU_FILE_OPC_LO  8
`define SIU_FILE_OPC_VAL 6'h02
`define SIU_DEST_BIT     7
`define SIU_ADDR_HI      6
`define SIU_LIT_HI       7
`define SIU_ACC_RST      8'h00
`define SIU_FLAG_RST     1'b0
`define SIU_ADDR_RST     7'h00
`define SIU_WDATA_RST    8'h00
`endif

// *** common/siu_pkg.sv ***
// Types shared by the subtract instruction unit.
// Assumes nothing beyond the constants header.
package siu_pkg;
  typedef enum logic [1:0] {SIU_IDLE, SIU_LIT, SIU_FILE} siu_op_e;
  typedef logic [7:0] siu_byte_t;
endpackage

// *** hw/siu_sub8.sv ***
// Eight-bit subtractor with borrow-free carry, digit carry and zero outputs.
// Assumes purely combinational use by the unit's result register.
module siu_sub8
  import siu_pkg::*;
(
  // Operands
  input  wire siu_byte_t minuend,
  input  wire siu_byte_t subtrahend,
  // Results
  output siu_byte_t      diff,
  output logic           carryOut,
  output logic           digitCarry,
  output logic           zeroOut
);
  logic [8:0] wide;
  logic [4:0] nib;
  // Two's complement: carry out of m + ~s + 1 means no borrow
  assign wide       = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001; // RULE1
  assign nib        = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
  assign diff       = wide[7:0];                                      // RULE6
  assign carryOut   = wide[8];                                        // RULE4 RULE5 RULE6
  assign digitCarry = nib[4];                                         // RULE7
  assign zeroOut    = (wide[7:0] == 8'h00);                           // RULE7
endmodule

// *** tb/subtract_instruction_unit_tb_top.sv ***
// Self-checking bench for the subtract instruction unit.
// Assumes the package is compiled first; the bench itself stands in for decode.
module subtract_instruction_unit_tb_top
  import siu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        sys_rst;
  logic        instrValid;
  logic [13:0] instrWord;
  siu_byte_t   fileData, accum, fileWdata, eAcc, eWd;
  logic        fileWe, carryFlag, digitCarryFlag, zeroFlag, eC, eDC, eZ, eWe;
  logic [6:0]  fileAddr, eAddr;
  int          n_fail, compares;

  always #4 mclk = ~mclk;

  subtract_instruction_unit u_subtract_instruction_unit (
    .mclk(mclk), .sys_rst(sys_rst), .instrValid(instrValid), .instrWord(instrWord),
    .fileData(fileData), .accum(accum), .fileWe(fileWe), .fileAddr(fileAddr),
    .fileWdata(fileWdata), .carryFlag(carryFlag), .digitCarryFlag(digitCarryFlag),
    .zeroFlag(zeroFlag));

  task automatic end_sim();
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chkAll();
    chk(accum, eAcc);
    chk({5'h00, carryFlag, digitCarryFlag, zeroFlag}, {5'h00, eC, eDC, eZ});
    chk({7'h00, fileWe}, {7'h00, eWe});
    chk({1'b0, fileAddr}, {1'b0, eAddr});
    chk(fileWdata, eWd);
  endtask

  // Reference result worked out from the instruction encodings alone
  task automatic predict(input logic [13:0] w, input siu_byte_t f, input logic v);
    siu_byte_t m, d;
    logic      isLit, isFile;
    isLit = w[13:9] == 5'h1e;
    isFile = w[13:8] == 6'h02;
    m = isLit ? w[7:0] : f;
    d = m - eAcc;
    eWe = 1'b0;
    if (v && (isLit || isFile)) begin
      eC = m >= eAcc;
      eDC = m[3:0] >= eAcc[3:0];
      eZ = d == 8'h00;
      eWe = isFile && w[7];
      if (isFile) begin
        eAddr = w[6:0];
        eWd = d;
      end
      if (!eWe) eAcc = d;
    end
  endtask

  task automatic drv(input logic [13:0] w, input siu_byte_t f, input logic v);
    instrValid <= v;
    instrWord <= w;
    fileData <= f;
  endtask

  // One instruction, then one idle cycle so it is not taken twice
  task automatic op(input logic [13:0] w, input siu_byte_t f, input logic v);
    predict(w, f, v);
    drv(w, f, v);
    @(posedge mclk);
    instrValid <= 1'b0;
    @(negedge mclk);
    chkAll();
    @(posedge mclk);
  endtask

  task automatic tLit();
    for (int i = 0; i < 3; i++) begin
      op({5'h1e, i[0], 8'(i + 1) + eAcc}, 8'h00, 1'b1);
      op({5'h1e, ~i[0], 8'h02}, 8'h00, 1'b1);
    end
  endtask

  task automatic tFile();
    op({6'h3c, 8'h02 + eAcc}, 8'h00, 1'b1);
    op({6'h02, 1'b1, 7'h7f}, 8'h03, 1'b1);
    op({6'h02, 1'b1, 7'h00}, 8'h02, 1'b1);
    op({6'h02, 1'b0, 7'h15}, 8'h01, 1'b1);
    op({6'h02, 1'b0, 7'h2a}, 8'h10, 1'b1);
    op({6'h02, 1'b1, 7'h40}, 8'hff, 1'b1);
    op({6'h02, 1'b0, 7'h01}, 8'h20, 1'b1);
    op({6'h02, 1'b1, 7'h33}, 8'h05, 1'b1);
  endtask

  task automatic tRefuse();
    op({5'h1e, 1'b0, 8'h55}, 8'h00, 1'b0);
    op(14'h3a55, 8'h00, 1'b1);
    op({6'h03, 1'b1, 7'h05}, 8'h33, 1'b1);
  endtask

  // Mid-run reset clears every output; the instruction is dropped before release
  task automatic tRst();
    drv({6'h3c, 8'h42}, 8'h00, 1'b1);
    sys_rst <= 1'b1;
    @(posedge mclk);
    instrValid <= 1'b0;
    {eAcc, eC, eDC, eZ, eWe, eAddr, eWd} = '0;
    @(negedge mclk);
    chkAll();
    @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
  endtask

  // Second instruction must see the accumulator left by the first
  task automatic tB2b();
    predict({6'h3c, 8'h80}, 8'h00, 1'b1);
    drv({6'h3c, 8'h80}, 8'h00, 1'b1);
    @(posedge mclk);
    drv({6'h02, 1'b1, 7'h7f}, 8'h85, 1'b1);
    @(negedge mclk);
    chkAll();
    predict({6'h02, 1'b1, 7'h7f}, 8'h85, 1'b1);
    @(posedge mclk);
    instrValid <= 1'b0;
    @(negedge mclk);
    chkAll();
    @(posedge mclk);
  endtask

  initial begin
    #100000;
    n_fail++;
    end_sim();
  end

  initial begin
    sys_rst <= 1'b1;
    drv(14'h0000, 8'h00, 1'b0);
    {eAcc, eC, eDC, eZ, eWe, eAddr, eWd} = '0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    chkAll();
    @(posedge mclk);
    tLit();
    tFile();
    tRefuse();
    tRst();
    tB2b();
    end_sim();
  end
endmodule
